// ### hw/bmc_pkg.sv
// Package for the basic mode control register bank.
// Assumes a single 125 MHz clock domain and a 5-bit register address port.
package bmc_pkg;
   // ----------------------------------------------------------------
   // Register map and field positions
   // ----------------------------------------------------------------
   localparam logic [4:0]  BMC_ADDR_CTRL   = 5'h00;
   localparam logic [4:0]  BMC_ADDR_LATCH  = 5'h01;
   localparam int          BMC_BIT_RESET   = 15;
   localparam int          BMC_BIT_LOOP    = 14;
   localparam int          BMC_BIT_SPEED   = 13;
   localparam int          BMC_BIT_ANEG    = 12;
   localparam int          BMC_BIT_PDOWN   = 11;
   localparam int          BMC_BIT_ISOLATE = 10;
   localparam int          BMC_BIT_DUPLEX  = 8;
   localparam logic [15:0] BMC_WR_MASK     = 16'hfd00;
   localparam logic [15:0] BMC_CTRL_RESET  = 16'h0000;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 8000;
   localparam int SRST_TIME_NS     = 1000;
   localparam int SRST_CYCLES      = (SRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOOP_DEAD_US     = 500;
   localparam int LOOP_DEAD_CYCLES = (LOOP_DEAD_US * 1000000) / CLK_PERIOD_PS;

   // Strap inputs that seed the configuration
   typedef struct packed {
      logic speed;
      logic aneg;
      logic duplex;
   } bmc_strap_t;

   // MII data path nibble group
   typedef struct packed {
      logic       en;
      logic       er;
      logic [3:0] data;
   } bmc_mii_t;
endpackage : bmc_pkg

// ### hw/bmc_counter.sv
// Down counter that times one interval after a start pulse.
// Assumes start is a one-cycle pulse in the ref_clk domain.
`timescale 1ns/1ps
module bmc_counter #(
   parameter int COUNT = 125
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Control
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_q, cnt_d;
   logic         done_d, done_q;

   // Next count; restart reloads the full interval
   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (start) begin
         cnt_d = W'(COUNT);
      end else if (cnt_q != '0) begin
         cnt_d  = cnt_q - 1'b1;
         done_d = (cnt_q == W'(1));
      end
   end

   // Registered state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign busy = (cnt_q != '0);
   assign done = done_q;
endmodule : bmc_counter

// ### hw/bmc_core.sv
// Basic mode control register bank with loopback, isolate and power-down gating.
// Assumes straps are stable at and after reset release and all inputs are synchronous.
// Behaviour
// - Latched-high and latched-low status bits hold their event until software reads them.
// - Writing one to bit 15 starts soft reset; reads one until done.
// - Soft reset completion reloads every strap-derived value as hardware reset does.
// - Loopback bit 14 routes MII transmit data into the receive path.
// - After loopback enable, receive outputs stay invalid for up to 500 us.
// - Without auto-negotiation, bit 13 selects 100 Mbps when one, 10 Mbps otherwise.
// - Bit 12 resets from strap; when one, bits 13 and 8 are ignored.
// - Power-down bit 11 silences mii_rx and line_tx only; mii_rx_oe and the timers keep running.
// - Power-down is bit OR pin; pin low also sets the bit.
// - Isolate bit 10 disconnects the MII data interface; management keeps working.
// - Without auto-negotiation, bit 8 selects full duplex when one; strap reset.
`timescale 1ns/1ps
module bmc_core
   import bmc_pkg::*;
#(
   parameter int DEAD_CYCLES = LOOP_DEAD_CYCLES
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Straps and pins
   input  wire bmc_strap_t  strap,
   input  wire logic        powerdown_interrupt_pin_n,
   // Events for latched status bits
   input  wire logic        link_ok,
   input  wire logic        fault_evt,
   // MII side
   input  wire bmc_mii_t    mii_tx,
   input  wire bmc_mii_t    line_rx,
   output bmc_mii_t         mii_rx,
   output bmc_mii_t         line_tx,
   output logic             mii_rx_oe,
   // Effective configuration
   output logic             cfg_speed_100,
   output logic             cfg_full_duplex,
   output logic             cfg_aneg,
   output logic             cfg_powerdown,
   output logic             soft_reset_active
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_STRAP, ST_RUN, ST_SRST} bmc_state_t;
   bmc_state_t  st_q, st_d;
   logic [15:0] ctrl_q, ctrl_d;
   logic        link_ll_q, link_ll_d;
   logic        fault_lh_q, fault_lh_d;
   logic [15:0] rdata_q, rdata_d;
   logic        loop_prev_q;
   logic        srst_start, srst_busy, srst_done;
   logic        dead_busy, dead_start;
   bmc_mii_t    mii_rx_d, mii_rx_q, line_tx_d, line_tx_q;
   logic        pd_eff;

   // Strap image shared by hardware and soft reset
   function automatic logic [15:0] strap_image(input bmc_strap_t s);
      logic [15:0] v;
      v                 = BMC_CTRL_RESET;
      v[BMC_BIT_SPEED]  = s.speed;
      v[BMC_BIT_ANEG]   = s.aneg;
      v[BMC_BIT_DUPLEX] = s.duplex;
      return v;
   endfunction : strap_image

   wire wr_ctrl  = reg_wr && (reg_addr == BMC_ADDR_CTRL);
   wire rd_latch = reg_rd && (reg_addr == BMC_ADDR_LATCH);

   // ----------------------------------------------------------------
   // Soft reset timer and loopback dead-time timer
   // ----------------------------------------------------------------
   assign srst_start = (st_q == ST_RUN) && wr_ctrl && reg_wdata[BMC_BIT_RESET];
   bmc_counter #(.COUNT(SRST_CYCLES)) u_srst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (srst_start),
      .busy    (srst_busy),
      .done    (srst_done)
   );

   assign dead_start = ctrl_q[BMC_BIT_LOOP] && !loop_prev_q;
   bmc_counter #(.COUNT(DEAD_CYCLES)) u_dead (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (dead_start),
      .busy    (dead_busy),
      .done    ()
   );

   // ----------------------------------------------------------------
   // Control register next state
   // ----------------------------------------------------------------
   // Straps are taken one edge after release, never inside the reset branch
   always_comb begin
      st_d   = st_q;
      ctrl_d = ctrl_q;
      case (st_q)
         ST_STRAP: begin
            ctrl_d = strap_image(strap);
            st_d   = ST_RUN;
         end
         ST_RUN: begin
            if (wr_ctrl) begin
               ctrl_d = (ctrl_q & ~BMC_WR_MASK) | (reg_wdata & BMC_WR_MASK);
            end
            if (srst_start) begin
               st_d = ST_SRST;
            end
         end
         ST_SRST: begin
            ctrl_d[BMC_BIT_RESET] = 1'b1;
            if (srst_done) begin
               ctrl_d = strap_image(strap);
               st_d   = ST_RUN;
            end
         end
         default: begin
            st_d = ST_STRAP;
         end
      endcase
      // Pin low forces the bit; it stays set after release until cleared
      if (!powerdown_interrupt_pin_n) begin
         ctrl_d[BMC_BIT_PDOWN] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Latched status, read data and data path next state
   // ----------------------------------------------------------------
   // Read clears the latch, but a new event in the same cycle wins
   always_comb begin
      link_ll_d  = rd_latch ? 1'b1 : link_ll_q;
      fault_lh_d = rd_latch ? 1'b0 : fault_lh_q;
      if (!link_ok) begin
         link_ll_d = 1'b0;
      end
      if (fault_evt) begin
         fault_lh_d = 1'b1;
      end
      rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            BMC_ADDR_CTRL:  rdata_d = ctrl_q;
            BMC_ADDR_LATCH: rdata_d = {14'h0000, fault_lh_q, link_ll_q};
            default:        rdata_d = 16'h0000;
         endcase
      end
   end

   assign pd_eff = ctrl_q[BMC_BIT_PDOWN] || !powerdown_interrupt_pin_n;

   // Data path: power-down and isolate silence both directions
   always_comb begin
      mii_rx_d  = '0;
      line_tx_d = '0;
      if (!pd_eff && !ctrl_q[BMC_BIT_ISOLATE] && (st_q == ST_RUN)) begin
         if (ctrl_q[BMC_BIT_LOOP]) begin
            // The start cycle is dead too; the timer only counts from the next edge
            mii_rx_d = (dead_busy || dead_start) ? '0 : mii_tx;
         end else begin
            mii_rx_d  = line_rx;
            line_tx_d = mii_tx;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q        <= ST_STRAP;
         ctrl_q      <= BMC_CTRL_RESET;
         link_ll_q   <= 1'b1;
         fault_lh_q  <= 1'b0;
         rdata_q     <= 16'h0000;
         loop_prev_q <= 1'b0;
         mii_rx_q    <= '0;
         line_tx_q   <= '0;
      end else begin
         st_q        <= st_d;
         ctrl_q      <= ctrl_d;
         link_ll_q   <= link_ll_d;
         fault_lh_q  <= fault_lh_d;
         rdata_q     <= rdata_d;
         loop_prev_q <= ctrl_q[BMC_BIT_LOOP];
         mii_rx_q    <= mii_rx_d;
         line_tx_q   <= line_tx_d;
      end
   end

   // Effective configuration, registered
   logic speed_q, duplex_q, aneg_q, pd_q, srst_q, oe_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_q  <= 1'b0;
         duplex_q <= 1'b0;
         aneg_q   <= 1'b0;
         pd_q     <= 1'b0;
         srst_q   <= 1'b0;
         oe_q     <= 1'b0;
      end else begin
         // Auto-negotiation owns speed and duplex; resolved result not modelled here
         speed_q  <= !ctrl_d[BMC_BIT_ANEG] && ctrl_d[BMC_BIT_SPEED];
         duplex_q <= !ctrl_d[BMC_BIT_ANEG] && ctrl_d[BMC_BIT_DUPLEX];
         aneg_q   <= ctrl_d[BMC_BIT_ANEG];
         pd_q     <= ctrl_d[BMC_BIT_PDOWN] || !powerdown_interrupt_pin_n;
         srst_q   <= (st_d != ST_RUN) || srst_busy;
         oe_q     <= !ctrl_d[BMC_BIT_ISOLATE];
      end
   end

   assign reg_rdata         = rdata_q;
   assign mii_rx            = mii_rx_q;
   assign line_tx           = line_tx_q;
   assign mii_rx_oe         = oe_q;
   assign cfg_speed_100     = speed_q;
   assign cfg_full_duplex   = duplex_q;
   assign cfg_aneg          = aneg_q;
   assign cfg_powerdown     = pd_q;
   assign soft_reset_active = srst_q;
endmodule : bmc_core

// ### sim/bmc_core_asserts.sv
// Checker for the basic mode control bank, bound to bmc_core.
// Assumes one ref_clk domain and the register port timing of the core.
`timescale 1ns/1ps
module bmc_core_asserts
   import bmc_pkg::*;
(
   // Watched ports
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [4:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        powerdown_interrupt_pin_n,
   input wire logic        fault_evt,
   input wire bmc_mii_t    mii_rx,
   input wire bmc_mii_t    line_tx,
   input wire logic        mii_rx_oe,
   input wire logic        cfg_speed_100,
   input wire logic        cfg_full_duplex,
   input wire logic        cfg_aneg,
   input wire logic        cfg_powerdown,
   input wire logic        soft_reset_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] srst_cnt_q;
   logic [7:0] srst_cnt_d;
   // Soft reset length; a stuck busy flag runs past the bound
   always_comb srst_cnt_d = soft_reset_active ? srst_cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) srst_cnt_q <= 8'h00;
      else srst_cnt_q <= srst_cnt_d;
   end
   sequence ctl_wr;
      reg_wr && reg_addr == BMC_ADDR_CTRL && !soft_reset_active && !reg_wdata[15];
   endsequence
   sequence latch_rd;
      reg_rd && reg_addr == BMC_ADDR_LATCH;
   endsequence
   a_speed_manual: assert property (ctl_wr ##0 !reg_wdata[12] |=>
      cfg_speed_100 == $past(reg_wdata[13])) else $error("speed not taken");
   a_duplex_manual: assert property (ctl_wr ##0 !reg_wdata[12] |=>
      cfg_full_duplex == $past(reg_wdata[8])) else $error("duplex not taken");
   a_aneg_follow: assert property (ctl_wr |=> cfg_aneg == $past(reg_wdata[12]))
      else $error("aneg not taken");
   a_aneg_masks: assert property (cfg_aneg |-> !cfg_speed_100 && !cfg_full_duplex)
      else $error("manual bits used under aneg");
   a_pin_pdown: assert property (!powerdown_interrupt_pin_n |-> ##[1:2] cfg_powerdown)
      else $error("pin did not power down");
   a_pdown_quiet: assert property (cfg_powerdown && $past(cfg_powerdown) |->
      mii_rx == '0 && line_tx == '0) else $error("data moves in power down");
   a_isolate_oe: assert property (ctl_wr ##0 reg_wdata[10] |-> ##[1:2] !mii_rx_oe)
      else $error("isolate left oe high");
   a_srst_start: assert property (reg_wr && reg_addr == BMC_ADDR_CTRL && reg_wdata[15] &&
      !soft_reset_active |-> ##[1:2] soft_reset_active[*8]) else $error("soft reset short");
   a_srst_bound: assert property (srst_cnt_q < 8'h8c)
      else $error("soft reset never ends");
   a_fault_latch: assert property (fault_evt ##1 latch_rd |=> reg_rdata[1])
      else $error("fault event lost");
   a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
endmodule : bmc_core_asserts
bind bmc_core bmc_core_asserts u_chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .powerdown_interrupt_pin_n, .fault_evt, .mii_rx, .line_tx,
   .mii_rx_oe, .cfg_speed_100, .cfg_full_duplex, .cfg_aneg, .cfg_powerdown,
   .soft_reset_active);

// ### sim/bmc_mac_model.sv
// Far-side model: MAC transmit nibbles and line receive nibbles.
// Assumes the core samples both groups on ref_clk rising edges.
`timescale 1ns/1ps
module bmc_mac_model
   import bmc_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Data toward the core
   output bmc_mii_t  mii_tx,
   output bmc_mii_t  line_rx
);
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   // New pattern every cycle so a stale or swapped path shows
   always_comb cnt_d = cnt_q + 6'h01;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 6'h00;
      else cnt_q <= cnt_d;
   end
   assign mii_tx  = bmc_mii_t'(cnt_q);
   assign line_rx = bmc_mii_t'(~cnt_q);
endmodule : bmc_mac_model

// ### sim/phy_basic_mode_control_bench.sv
// Testbench for the basic mode control bank and its data path gating.
// Assumes the core's register port contract and a 20-cycle loopback dead time.
`timescale 1ns/1ps
module phy_basic_mode_control_bench import bmc_pkg::*;;
   logic        ref_clk, rst_n, reg_wr, reg_rd, powerdown_interrupt_pin_n, link_ok, fault_evt;
   logic        mii_rx_oe, cfg_speed_100, cfg_full_duplex, cfg_aneg, cfg_powerdown;
   logic        soft_reset_active;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   bmc_strap_t  strap;
   bmc_mii_t    mii_tx, line_rx, mii_rx, line_tx, tx_s, rx_s;
   int          errors = 0;
   int          checks_done = 0;
   bmc_core #(.DEAD_CYCLES(20)) DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .strap, .powerdown_interrupt_pin_n, .link_ok, .fault_evt,
      .mii_tx, .line_rx, .mii_rx, .line_tx, .mii_rx_oe, .cfg_speed_100, .cfg_full_duplex,
      .cfg_aneg, .cfg_powerdown, .soft_reset_active);
   bmc_mac_model u_model (.ref_clk, .rst_n, .mii_tx, .line_rx);
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   // One registered hop: sample the far side off the edge, compare after it
   task automatic path(input logic lb, input logic on);
      #1;
      tx_s = mii_tx;
      rx_s = line_rx;
      @(posedge ref_clk);
      #1;
      chk("mii_rx", on ? {10'h000, lb ? tx_s : rx_s} : 16'h0000, {10'h000, mii_rx});
      chk("line_tx", (on && !lb) ? {10'h000, tx_s} : 16'h0000, {10'h000, line_tx});
   endtask : path
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Tests need under 625 cycles; ten times that means a hang
   initial begin
      #50000;
      errors++;
      wrap_up();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, fault_evt, reg_addr, reg_wdata} = '0;
      {powerdown_interrupt_pin_n, link_ok} = 2'b11;
      strap = '{speed: 1'b1, aneg: 1'b0, duplex: 1'b1};
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(BMC_ADDR_CTRL);
      chk("reset image", 16'h2100, rv);
      chk("cfg straps", 16'h0003, {14'h0, cfg_speed_100, cfg_full_duplex});
      wr(BMC_ADDR_CTRL, 16'h0000);
      chk("manual 10 half", 16'h0000, {14'h0, cfg_speed_100, cfg_full_duplex});
      wr(BMC_ADDR_CTRL, 16'h31ff);
      chk("aneg masks", 16'h0004, {13'h0, cfg_aneg, cfg_speed_100, cfg_full_duplex});
      rd(BMC_ADDR_CTRL);
      chk("reserved bits", 16'h3100, rv);
      rd(5'h07);
      chk("unmapped", 16'h0000, rv);
      $display("test config done");
      wr(BMC_ADDR_CTRL, 16'h4000);
      path(1'b1, 1'b0);
      repeat (24) @(posedge ref_clk);
      path(1'b1, 1'b1);
      wr(BMC_ADDR_CTRL, 16'h0000);
      path(1'b0, 1'b1);
      wr(BMC_ADDR_CTRL, 16'h0400);
      path(1'b0, 1'b0);
      chk("oe isolate", 16'h0000, {15'h0, mii_rx_oe});
      rd(BMC_ADDR_CTRL);
      chk("isolate readback", 16'h0400, rv);
      wr(BMC_ADDR_CTRL, 16'h0800);
      path(1'b0, 1'b0);
      rd(BMC_ADDR_CTRL);
      chk("pdown readback", 16'h0800, rv);
      chk("oe restored", 16'h0001, {15'h0, mii_rx_oe});
      wr(BMC_ADDR_CTRL, 16'h0000);
      @(posedge ref_clk);
      powerdown_interrupt_pin_n <= 1'b0;
      @(posedge ref_clk);
      powerdown_interrupt_pin_n <= 1'b1;
      rd(BMC_ADDR_CTRL);
      chk("pin sets bit", 16'h0800, rv);
      chk("pin powers down", 16'h0001, {15'h0, cfg_powerdown});
      $display("test data path done");
      @(posedge ref_clk);
      fault_evt <= 1'b1;
      link_ok <= 1'b0;
      // Read strobe right behind the events, so the latch must already hold them
      @(posedge ref_clk);
      fault_evt <= 1'b0;
      link_ok <= 1'b1;
      reg_rd <= 1'b1;
      reg_addr <= BMC_ADDR_LATCH;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      chk("latched events", 16'h0002, rv);
      rd(BMC_ADDR_LATCH);
      chk("after read", 16'h0001, rv);
      $display("test latched done");
      @(posedge ref_clk);
      strap <= '{speed: 1'b0, aneg: 1'b1, duplex: 1'b0};
      wr(BMC_ADDR_CTRL, 16'h8000);
      rd(BMC_ADDR_CTRL);
      chk("reset bit busy", 16'h8000, rv & 16'h8000);
      wr(BMC_ADDR_CTRL, 16'h2100);
      repeat (200) if (soft_reset_active === 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      chk("soft reset ends", 16'h0000, {15'h0, soft_reset_active});
      rd(BMC_ADDR_CTRL);
      chk("restrapped", 16'h1000, rv);
      chk("aneg restrapped", 16'h0001, {15'h0, cfg_aneg});
      $display("test soft reset done");
      wrap_up();
   end
endmodule : phy_basic_mode_control_bench
